/* File: shared/odt_pkg.sv */
// constants for the optical drive task file block
package odt_pkg;
  // register byte addresses
  localparam logic [31:0] ADDR_DATA = 32'h005f7080;
  localparam logic [31:0] ADDR_ERR_FEAT = 32'h005f7084;
  localparam logic [31:0] ADDR_REASON_SCNT = 32'h005f7088;
  localparam logic [31:0] ADDR_SECNUM = 32'h005f708c;
  localparam logic [31:0] ADDR_BCNT_LO = 32'h005f7090;
  localparam logic [31:0] ADDR_BCNT_HI = 32'h005f7094;
  localparam logic [31:0] ADDR_UNIT_SEL = 32'h005f7098;
  localparam logic [31:0] ADDR_STAT_CMD = 32'h005f709c;
  // command codes
  localparam logic [7:0] CMD_NOP = 8'h00;
  localparam logic [7:0] CMD_SRST = 8'h08;
  localparam logic [7:0] CMD_DIAG = 8'h90;
  localparam logic [7:0] CMD_PKT = 8'ha0;
  localparam logic [7:0] CMD_IDENT = 8'ha1;
  localparam logic [7:0] CMD_SETF = 8'hef;
  // error register values
  localparam logic [7:0] ERR_ABORT = 8'h04;
  localparam logic [7:0] ERR_NONE = 8'h00;
  localparam logic [7:0] DIAG_OK = 8'h00;
  localparam logic [7:0] DIAG_BUF = 8'h03;
  localparam logic [7:0] DIAG_CTRL = 8'h04;
  localparam logic [7:0] DIAG_CPU = 8'h05;
  localparam logic [7:0] DIAG_SERVO = 8'h06;
  localparam logic [7:0] DIAG_OTHER = 8'h07;
  // set features fields
  localparam int unsigned FEAT_SET_BIT = 7;
  localparam logic [6:0] FEAT_XFER_MODE = 7'h03;
  localparam int unsigned FEAT_DMA_BIT = 0;
  localparam logic [4:0] METH_PIO_DEF = 5'h00;
  localparam logic [4:0] METH_PIO_FLOW = 5'h01;
  localparam logic [4:0] METH_DMA_SW = 5'h02;
  localparam logic [4:0] METH_DMA_MW = 5'h04;
  localparam logic [7:0] PIO_MODE_RST = 8'h00;
  localparam logic [7:0] DMA_MODE_RST = 8'h10;
  // unit select fixed pattern, bits 7..4
  localparam logic [3:0] UNIT_SEL_FIXED = 4'ha;
  // identify block
  localparam int unsigned IDENT_LEN = 80;
  localparam logic [15:0] IDENT_BCNT = 16'h0050;
  localparam logic [6:0] IDENT_LAST = 7'h4f;
  // timing
  localparam int unsigned CLK_NS = 4;
  localparam int unsigned CMD_BUSY_NS = 400;
  localparam int unsigned CMD_BUSY_CYC = CMD_BUSY_NS / CLK_NS;
  localparam int unsigned SRST_NS = 2000;
  localparam int unsigned SRST_CYC = (SRST_NS + CLK_NS - 1) / CLK_NS;
  localparam logic [15:0] BCNT_RST = 16'h0000;
  typedef enum logic [2:0] {
    ODT_IDLE, ODT_DISPATCH, ODT_SRST, ODT_DIAG, ODT_IDENT, ODT_PKT
  } odt_state_t;
endpackage : odt_pkg

/* File: rtl/odt_timer.sv */
// down counter that pulses when a loaded delay has run out
`timescale 1ns/1ns
module odt_timer #(
  parameter int unsigned WIDTH = 10
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic nrst_i,
  // control
  input wire logic start_i,
  input wire logic [WIDTH-1:0] count_i,
  output logic done_o
);
  logic [WIDTH-1:0] cnt;
  logic run;
  always_ff @(posedge clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      cnt <= '0;
      run <= 1'b0;
      done_o <= 1'b0;
    end
    else
    begin
      done_o <= run && (cnt == '0);
      if (start_i)
      begin
        cnt <= count_i;
        run <= 1'b1;
      end
      else if (run && (cnt == '0))
        run <= 1'b0;
      else if (run)
        cnt <= cnt - 1'b1;
    end
  end
endmodule : odt_timer

/* File: rtl/odt_ident_rom.sv */
// identify data memory with registered read port
`timescale 1ns/1ns
module odt_ident_rom #(
  // arbitrary neutral identity values
  parameter logic [7:0] MAKER_ID = 8'h5a,
  parameter logic [7:0] MODEL_ID = 8'h01,
  parameter logic [7:0] VERSION_ID = 8'h01,
  parameter logic [127:0] MAKER_NAME = "GENERIC MAKER   ",
  parameter logic [127:0] MODEL_NAME = "OPTICAL DRIVE   ",
  parameter logic [127:0] FW_NAME = "FW 1.00         "
) (
  // clock
  input wire logic clk_i,
  // read port
  input wire logic [6:0] addr_i,
  output logic [7:0] data_o
);
  // ascii fields sit first character in the top byte
  function automatic logic [7:0] pick(input logic [127:0] s,
                                      input logic [3:0] i);
    pick = s[8*(15-i) +: 8];
  endfunction : pick
  logic [7:0] next_data;
  always_comb
  begin
    unique case (addr_i[6:4])
      3'h0:
        next_data = (addr_i[3:0] == 4'h0) ? MAKER_ID :
                    (addr_i[3:0] == 4'h1) ? MODEL_ID :
                    (addr_i[3:0] == 4'h2) ? VERSION_ID : 8'h00;
      3'h1: next_data = pick(MAKER_NAME, addr_i[3:0]);
      3'h2: next_data = pick(MODEL_NAME, addr_i[3:0]);
      3'h3: next_data = pick(FW_NAME, addr_i[3:0]);
      default: next_data = 8'h00;
    endcase
  end
  always_ff @(posedge clk_i)
  begin
    data_o <= next_data;
  end
endmodule : odt_ident_rom

/* File: rtl/odt_task_file.sv */
// task file register block of the optical drive, device side
`timescale 1ns/1ns
// Function
// RL1: byte count low and high bytes
// RL2: byte count ignored in dma mode
// RL3: host loads byte count before packet
// RL4: host loads total length for multi requests
// RL5: load byte count, then raise data request
// RL6: byte count frozen while data request set
// RL7: unit select fixed bits and unit field
// RL8: status read clears pending interrupt
// RL9: busy blocks command block access
// RL10: busy set within 400 ns of command
// RL11: status byte bit layout
// RL12: data request set when transfer possible
// RL13: error flag set on any error
// RL14: command valid only on code write
// RL15: recognise five supported command codes
// RL16: nop or unknown aborts with interrupt
// RL17: soft reset reinitialises, starts stopped motor
// RL18: diagnostics report, clear busy, interrupt
// RL19: diagnostics code lands in error register
// RL20: identify returns ids and ascii names
// RL21: host set features write sequence
// RL22: separate pio and dma mode selections
// RL23: reason bits with request give phase
// RL24: sector count method encodings
// RL25: host polls busy before writing
module odt_task_file
  import odt_pkg::*;
#(
  parameter int unsigned SRST_W = 10
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic nrst_i,
  // register port
  input wire logic [31:0] addr_i,
  input wire logic [31:0] wdata_i,
  input wire logic we_i,
  input wire logic re_i,
  output logic [31:0] rdata_o,
  // interrupt line to host
  output logic intrq_o,
  // drive condition inputs
  input wire logic drv_ready_i,
  input wire logic fault_i,
  input wire logic seek_done_i,
  input wire logic corrected_i,
  input wire logic motor_stopped_i,
  input wire logic [7:0] disc_state_i,
  // drive engine controls
  output logic motor_start_o,
  output logic diag_start_o,
  input wire logic diag_done_i,
  input wire logic [7:0] diag_code_i,
  output logic pkt_start_o,
  output logic dma_sel_o,
  // packet transfer phases from the drive engine
  input wire logic xfer_req_i,
  input wire logic xfer_dir_i,
  input wire logic [15:0] xfer_count_i,
  input wire logic xfer_end_i,
  input wire logic cmd_done_i,
  input wire logic cmd_err_i,
  // settings out
  output logic [3:0] logical_unit_field_o,
  output logic [7:0] pio_mode_o,
  output logic [7:0] dma_mode_o
);
  import odt_pkg::*;

  function automatic logic hit(input logic [31:0] a, input logic [31:0] r);
    hit = (a == r);
  endfunction : hit

  odt_state_t state;
  odt_state_t next_state;
  logic busy;
  logic drq;
  logic io;
  logic cod;
  logic check;
  logic intr;
  logic drq_pend;
  logic [7:0] err_reg;
  logic [7:0] features;
  logic [7:0] sec_cnt;
  logic [15:0] bcount;
  logic [3:0] logical_unit_field;
  logic [7:0] cmd_code;
  logic [6:0] id_ptr;
  logic [7:0] rom_q;
  logic rd_rom;
  logic [31:0] rd_reg;
  logic srst_done;

  // host access decode
  wire wr_ok = ~busy & ~drq; // RL9 RL25
  wire wr_cmd = we_i & hit(addr_i, ADDR_STAT_CMD);
  wire cmd_take = wr_cmd & (wr_ok | (wdata_i[7:0] == CMD_SRST)); // RL14
  wire wr_feat = we_i & hit(addr_i, ADDR_ERR_FEAT) & wr_ok;
  wire wr_scnt = we_i & hit(addr_i, ADDR_REASON_SCNT) & wr_ok;
  wire wr_bc_lo = we_i & hit(addr_i, ADDR_BCNT_LO) & wr_ok; // RL6
  wire wr_bc_hi = we_i & hit(addr_i, ADDR_BCNT_HI) & wr_ok; // RL6
  wire wr_unit = we_i & hit(addr_i, ADDR_UNIT_SEL) & wr_ok;
  wire rd_stat = re_i & hit(addr_i, ADDR_STAT_CMD);
  wire rd_data = re_i & hit(addr_i, ADDR_DATA) & (state == ODT_IDENT) & drq;
  wire id_last = rd_data & (id_ptr == IDENT_LAST);

  // dispatch decode
  wire is_srst = state == ODT_DISPATCH && cmd_code == CMD_SRST;
  wire is_diag = state == ODT_DISPATCH && cmd_code == CMD_DIAG;
  wire is_pkt = state == ODT_DISPATCH && cmd_code == CMD_PKT;
  wire is_ident = state == ODT_DISPATCH && cmd_code == CMD_IDENT;
  wire is_setf = state == ODT_DISPATCH && cmd_code == CMD_SETF;
  wire known = (cmd_code == CMD_SRST) | (cmd_code == CMD_DIAG) |
               (cmd_code == CMD_PKT) | (cmd_code == CMD_IDENT) |
               (cmd_code == CMD_SETF); // RL15
  wire [4:0] meth = sec_cnt[7:3];
  wire meth_pio = (meth == METH_PIO_DEF) | (meth == METH_PIO_FLOW); // RL24
  wire meth_dma = (meth == METH_DMA_SW) | (meth == METH_DMA_MW); // RL24
  wire feat_ok = features[FEAT_SET_BIT] &
                 (features[6:0] == FEAT_XFER_MODE); // RL21
  wire setf_pio = is_setf & feat_ok & meth_pio; // RL22
  wire setf_dma = is_setf & feat_ok & meth_dma; // RL22
  wire abort = (state == ODT_DISPATCH) & (~known |
               (is_setf & ~(setf_pio | setf_dma))); // RL16
  wire setf_fin = setf_pio | setf_dma;
  wire diag_fin = (state == ODT_DIAG) & diag_done_i;
  wire pkt_req = (state == ODT_PKT) & xfer_req_i & ~drq & ~drq_pend;
  wire pkt_end = (state == ODT_PKT) & xfer_end_i & drq;
  wire pkt_fin = (state == ODT_PKT) & cmd_done_i;
  wire srst_fin = (state == ODT_SRST) & srst_done;
  wire bc_load = is_ident | (pkt_req & ~dma_sel_o); // RL2
  wire int_set = abort | setf_fin | diag_fin | pkt_fin | id_last |
                 drq_pend;

  // state sequencing
  always_comb
  begin
    next_state = state;
    unique case (state)
      ODT_IDLE: if (cmd_take) next_state = ODT_DISPATCH;
      ODT_DISPATCH:
        if (is_srst) next_state = ODT_SRST;
        else if (is_diag) next_state = ODT_DIAG;
        else if (is_pkt) next_state = ODT_PKT;
        else if (is_ident) next_state = ODT_IDENT;
        else next_state = ODT_IDLE;
      ODT_SRST: if (srst_done) next_state = ODT_IDLE;
      ODT_DIAG: if (diag_done_i) next_state = ODT_IDLE;
      ODT_IDENT: if (id_last) next_state = ODT_IDLE;
      ODT_PKT: if (cmd_done_i) next_state = ODT_IDLE;
    endcase
    if (cmd_take && cmd_code != CMD_SRST && wdata_i[7:0] == CMD_SRST)
      next_state = ODT_DISPATCH;
  end

  always_ff @(posedge clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
      state <= ODT_IDLE;
    else
      state <= next_state;
  end

  always_ff @(posedge clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
      cmd_code <= CMD_NOP;
    else if (cmd_take)
      cmd_code <= wdata_i[7:0];
  end

  // busy flag: set on the edge that takes the command
  always_ff @(posedge clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
      busy <= 1'b0;
    else if (cmd_take | pkt_end)
      busy <= 1'b1; // RL10
    else if (abort | setf_fin | diag_fin | srst_fin | pkt_fin | drq_pend |
             is_pkt)
      busy <= 1'b0; // RL16 RL18
  end

  // data request and phase bits
  always_ff @(posedge clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      drq <= 1'b0;
      drq_pend <= 1'b0;
      io <= 1'b0;
      cod <= 1'b0;
    end
    else
    begin
      drq_pend <= bc_load | (pkt_req & dma_sel_o); // RL5
      if (drq_pend)
      begin
        drq <= 1'b1; // RL5 RL12
        io <= (state == ODT_IDENT) | xfer_dir_i; // RL23
        cod <= 1'b0; // RL23
      end
      else if (is_pkt)
      begin
        drq <= 1'b1; // RL12
        io <= 1'b0; // RL23
        cod <= 1'b1; // RL23
      end
      else if (id_last | pkt_fin)
      begin
        drq <= 1'b0;
        io <= 1'b1; // RL23
        cod <= 1'b1; // RL23
      end
      else if (pkt_end | srst_fin)
        drq <= 1'b0;
    end
  end

  // error flag and error register
  always_ff @(posedge clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      check <= 1'b0;
      err_reg <= ERR_NONE;
    end
    else if (abort)
    begin
      check <= 1'b1; // RL13 RL16
      err_reg <= ERR_ABORT; // RL16
    end
    else if (diag_fin)
    begin
      check <= 1'b0;
      err_reg <= diag_code_i; // RL18 RL19
    end
    else if (pkt_fin)
      check <= cmd_err_i; // RL13
    else if (cmd_take | srst_fin)
    begin
      check <= 1'b0;
      err_reg <= ERR_NONE;
    end
  end

  // interrupt: a new event in the clearing cycle wins
  always_ff @(posedge clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
      intr <= 1'b0;
    else if (int_set)
      intr <= 1'b1;
    else if (rd_stat | srst_fin)
      intr <= 1'b0; // RL8
  end
  assign intrq_o = intr;

  // byte count, host writes only outside a data request
  always_ff @(posedge clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
      bcount <= BCNT_RST;
    else if (srst_fin)
      bcount <= BCNT_RST;
    else if (is_ident)
      bcount <= IDENT_BCNT; // RL5 RL20
    else if (bc_load)
      bcount <= xfer_count_i; // RL5
    else
    begin
      if (wr_bc_lo)
        bcount[7:0] <= wdata_i[7:0]; // RL1 RL3 RL4
      if (wr_bc_hi)
        bcount[15:8] <= wdata_i[7:0]; // RL1 RL3 RL4
    end
  end

  // parameter registers of the command block
  always_ff @(posedge clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      features <= 8'h00;
      sec_cnt <= 8'h00;
      logical_unit_field <= 4'h0;
    end
    else if (srst_fin)
    begin
      features <= 8'h00;
      sec_cnt <= 8'h00;
      logical_unit_field <= 4'h0;
    end
    else
    begin
      if (wr_feat)
        features <= wdata_i[7:0];
      if (wr_scnt)
        sec_cnt <= wdata_i[7:0];
      if (wr_unit)
        logical_unit_field <= wdata_i[3:0]; // RL7
    end
  end
  assign logical_unit_field_o = logical_unit_field;

  // transfer modes, each kind set on its own
  always_ff @(posedge clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      pio_mode_o <= PIO_MODE_RST;
      dma_mode_o <= DMA_MODE_RST;
      dma_sel_o <= 1'b0;
    end
    else if (srst_fin)
    begin
      pio_mode_o <= PIO_MODE_RST; // RL17
      dma_mode_o <= DMA_MODE_RST; // RL17
      dma_sel_o <= 1'b0;
    end
    else
    begin
      if (setf_pio)
        pio_mode_o <= sec_cnt; // RL22
      if (setf_dma)
        dma_mode_o <= sec_cnt; // RL22
      if (is_pkt)
        dma_sel_o <= features[FEAT_DMA_BIT]; // RL2
    end
  end

  // engine pulses
  always_ff @(posedge clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      motor_start_o <= 1'b0;
      diag_start_o <= 1'b0;
      pkt_start_o <= 1'b0;
    end
    else
    begin
      motor_start_o <= srst_fin & motor_stopped_i; // RL17
      diag_start_o <= is_diag; // RL18
      pkt_start_o <= is_pkt;
    end
  end

  // soft reset hold time
  odt_timer #(
    .WIDTH(SRST_W)
  ) u_srst_timer (
    .clk_i(clk_i),
    .nrst_i(nrst_i),
    .start_i(is_srst),
    .count_i(SRST_W'(SRST_CYC - 1)),
    .done_o(srst_done)
  ); // RL17

  // identify data pointer
  always_ff @(posedge clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
      id_ptr <= 7'h00;
    else if (is_ident)
      id_ptr <= 7'h00;
    else if (rd_data)
      id_ptr <= id_ptr + 7'h01;
  end

  odt_ident_rom u_ident_rom (
    .clk_i(clk_i),
    .addr_i(id_ptr),
    .data_o(rom_q)
  ); // RL20

  // register read side
  wire [7:0] status_byte = {busy, drv_ready_i, fault_i, seek_done_i, drq,
                            corrected_i, 1'b0, check}; // RL11 RL9
  wire [7:0] reason_byte = {6'h00, io, cod}; // RL23
  wire [7:0] unit_byte = {UNIT_SEL_FIXED, logical_unit_field}; // RL7
  wire [7:0] rd_sel =
    hit(addr_i, ADDR_STAT_CMD) ? status_byte :
    hit(addr_i, ADDR_ERR_FEAT) ? err_reg :
    hit(addr_i, ADDR_REASON_SCNT) ? reason_byte :
    hit(addr_i, ADDR_SECNUM) ? disc_state_i :
    hit(addr_i, ADDR_BCNT_LO) ? bcount[7:0] : // RL1
    hit(addr_i, ADDR_BCNT_HI) ? bcount[15:8] : // RL1
    hit(addr_i, ADDR_UNIT_SEL) ? unit_byte : 8'h00;

  always_ff @(posedge clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      rd_reg <= 32'h00000000;
      rd_rom <= 1'b0;
    end
    else
    begin
      rd_rom <= rd_data;
      rd_reg <= re_i ? {24'h000000, rd_sel} : 32'h00000000;
    end
  end

  // the memory already registers its byte, so only the lane is muxed here
  assign rdata_o = rd_rom ? {24'h000000, rom_q} : rd_reg;

endmodule : odt_task_file

/* File: testbench/odt_host_model.sv */
// host bus model issuing task file register cycles
`timescale 1ns/1ns
module odt_host_model
  import odt_pkg::*;
(
  // clock
  input wire logic clk_i,
  // register port
  input wire logic [31:0] rdata_i,
  output logic [31:0] addr_o,
  output logic [31:0] wdata_o,
  output logic we_o,
  output logic re_o
);
  initial
    {addr_o, wdata_o, we_o, re_o} = 66'h0;
  // returns just after the taking edge, so calls may run back to back
  task wr(input logic [31:0] a, input logic [7:0] d);
    addr_o <= a;
    wdata_o <= {24'h0, d};
    we_o <= 1'b1;
    @(posedge clk_i);
    we_o <= 1'b0;
    #1;
  endtask : wr
  task rd(input logic [31:0] a, output logic [31:0] d);
    addr_o <= a;
    re_o <= 1'b1;
    @(posedge clk_i);
    re_o <= 1'b0;
    #1;
    d = rdata_i;
  endtask : rd
  // bounded poll; status reads also clear a pending interrupt
  task poll(output logic [31:0] d);
    int n;
    n = 0;
    d = 32'h80;
    while (d[7] !== 1'b0 && n < 1000)
    begin
      rd(ADDR_STAT_CMD, d);
      n++;
    end
  endtask : poll
endmodule : odt_host_model

/* File: testbench/odt_task_file_assertions.sv */
// port level checker for the task file block
`timescale 1ns/1ns
module odt_task_file_assertions
  import odt_pkg::*;
(
  // clock and reset
  input wire logic clk_i,
  input wire logic nrst_i,
  // register port
  input wire logic [31:0] addr_i,
  input wire logic [31:0] wdata_i,
  input wire logic we_i,
  input wire logic re_i,
  input wire logic [31:0] rdata_o,
  input wire logic intrq_o,
  // engine side
  input wire logic diag_done_i,
  input wire logic [7:0] diag_code_i,
  input wire logic xfer_req_i,
  input wire logic cmd_done_i,
  input wire logic motor_stopped_i,
  input wire logic motor_start_o,
  input wire logic pkt_start_o,
  input wire logic [3:0] logical_unit_field_o
);
  wire logic st_rd = re_i && addr_i == ADDR_STAT_CMD;
  wire logic cmd_wr = we_i && addr_i == ADDR_STAT_CMD;
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!nrst_i);
  // a fresh event at the same edge wins over the clear
  a_status_read_clears: assert property (st_rd && !diag_done_i && !cmd_done_i
    && !$past(xfer_req_i) && !$past(we_i) && !$past(we_i, 2) |=> !intrq_o)
    else $error("interrupt still pending after status read");
  a_srst_busy_seen: assert property (cmd_wr && wdata_i[7:0] == CMD_SRST
    ##1 st_rd |=> rdata_o[7]) else $error("busy not set");
  a_nop_flags_error: assert property (cmd_wr && wdata_i[7:0] == CMD_NOP
    ##2 st_rd |=> rdata_o[7] || rdata_o[3] || rdata_o[0])
    else $error("no-op did not flag error");
  a_diag_done_irq: assert property (diag_done_i |=> intrq_o)
    else $error("no interrupt after diagnostics");
  a_diag_code_lands: assert property (diag_done_i ##1
    (re_i && addr_i == ADDR_ERR_FEAT) |=> rdata_o[7:0] ==
    $past(diag_code_i, 2)) else $error("diag code lost");
  a_unit_sel_fixed: assert property (re_i && addr_i == ADDR_UNIT_SEL |=>
    rdata_o == {24'h0, UNIT_SEL_FIXED, $past(logical_unit_field_o)})
    else $error("unit select readback wrong");
  a_status_layout: assert property (st_rd |=> rdata_o[31:8] == 24'h0
    && !rdata_o[1]) else $error("status reserved bits set");
  a_pkt_start_cause: assert property ($rose(pkt_start_o) |->
    $past(cmd_wr && wdata_i[7:0] == CMD_PKT, 2))
    else $error("packet start without command");
  a_motor_cause: assert property (motor_start_o |-> $past(motor_stopped_i))
    else $error("motor start while running");
endmodule : odt_task_file_assertions

/* File: testbench/odt_task_file_bench.sv */
// self-checking bench for the task file block
`timescale 1ns/1ns
module odt_task_file_bench;
  import odt_pkg::*;
  logic clk_i;
  logic nrst_i;
  wire logic [31:0] addr, wdata, rdata;
  wire logic we, re, intrq, motor_start, diag_start, pkt_start, dma_sel;
  wire logic [3:0] logical_unit_field;
  // drive condition levels: ready, fault, seek, corrected
  logic [3:0] cond = 4'b1101;
  wire logic [7:0] pio_mode, dma_mode;
  logic motor_stopped = 1'b0;
  logic diag_done = 1'b0;
  logic [7:0] diag_code = 8'h00;
  logic xfer_req = 1'b0;
  logic xfer_dir = 1'b0;
  logic [15:0] xfer_count = 16'h0;
  logic xfer_end = 1'b0;
  logic cmd_done = 1'b0;
  logic cmd_err = 1'b0;
  logic motor_seen = 1'b0;
  logic [7:0] exp_pio = PIO_MODE_RST;
  logic [7:0] exp_dma = DMA_MODE_RST;
  logic [7:0] codes [6] = '{DIAG_OK, DIAG_BUF, DIAG_CTRL, DIAG_CPU,
    DIAG_SERVO, DIAG_OTHER};
  int n_errors = 0;
  int check_count = 0;
  initial
  begin
    clk_i = 1'b0;
    forever #2 clk_i = ~clk_i;
  end
  odt_host_model host_u (.clk_i(clk_i), .rdata_i(rdata), .addr_o(addr),
    .wdata_o(wdata), .we_o(we), .re_o(re));
  odt_task_file dut_u (.clk_i(clk_i), .nrst_i(nrst_i), .addr_i(addr),
    .wdata_i(wdata), .we_i(we), .re_i(re), .rdata_o(rdata),
    .intrq_o(intrq), .drv_ready_i(cond[3]), .fault_i(cond[2]),
    .seek_done_i(cond[1]), .corrected_i(cond[0]),
    .motor_stopped_i(motor_stopped), .disc_state_i(8'h12),
    .motor_start_o(motor_start), .diag_start_o(diag_start),
    .diag_done_i(diag_done), .diag_code_i(diag_code),
    .pkt_start_o(pkt_start), .dma_sel_o(dma_sel), .xfer_req_i(xfer_req),
    .xfer_dir_i(xfer_dir), .xfer_count_i(xfer_count),
    .xfer_end_i(xfer_end), .cmd_done_i(cmd_done), .cmd_err_i(cmd_err),
    .logical_unit_field_o(logical_unit_field), .pio_mode_o(pio_mode),
    .dma_mode_o(dma_mode));
  // the motor pulse is one cycle long and would slip past a poll
  always @(posedge clk_i)
    if (motor_start === 1'b1)
      motor_seen <= 1'b1;
  task chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp)
    begin
      n_errors++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task rchk(input logic [31:0] a, input logic [31:0] e);
    logic [31:0] d;
    host_u.rd(a, d);
    chk(d, e);
  endtask : rchk
  task wait_n(input int n);
    repeat (n) @(posedge clk_i);
    #1;
  endtask : wait_n
  task test_done;
    if (n_errors == 0 && check_count > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : test_done
  task t_idle;
    chk(pio_mode, PIO_MODE_RST);
    chk(dma_mode, DMA_MODE_RST);
    rchk(ADDR_STAT_CMD, 32'h64);
    // a second pattern tells ready from fault and seek from reserved
    cond <= 4'b0110;
    rchk(ADDR_STAT_CMD, 32'h30);
    cond <= 4'b1101;
    rchk(ADDR_UNIT_SEL, 32'ha0);
    rchk(ADDR_SECNUM, 32'h12);
    rchk(32'h005f70a0, 32'h0);
    host_u.wr(ADDR_UNIT_SEL, 8'h55);
    rchk(ADDR_UNIT_SEL, 32'ha5);
    chk(logical_unit_field, 4'h5);
  endtask : t_idle
  task t_abort(input logic [7:0] c);
    host_u.wr(ADDR_STAT_CMD, c);
    wait_n(1);
    chk(intrq, 1'b1);
    rchk(ADDR_STAT_CMD, 32'h65);
    chk(intrq, 1'b0);
    rchk(ADDR_ERR_FEAT, ERR_ABORT);
  endtask : t_abort
  task t_setf(input logic [7:0] sc);
    if (sc[7:4] == 4'h0)
      exp_pio = sc;
    else
      exp_dma = sc;
    host_u.wr(ADDR_ERR_FEAT, 8'h83);
    host_u.wr(ADDR_REASON_SCNT, sc);
    host_u.wr(ADDR_STAT_CMD, CMD_SETF);
    wait_n(1);
    chk(intrq, 1'b1);
    chk(pio_mode, exp_pio);
    chk(dma_mode, exp_dma);
    rchk(ADDR_STAT_CMD, 32'h64);
  endtask : t_setf
  task t_diag(input logic [7:0] c);
    host_u.wr(ADDR_STAT_CMD, CMD_DIAG);
    wait_n(1);
    chk(diag_start, 1'b1);
    // a write while busy must be dropped
    host_u.wr(ADDR_UNIT_SEL, 8'h03);
    {diag_code, diag_done} <= {c, 1'b1};
    wait_n(1);
    diag_done <= 1'b0;
    chk(intrq, 1'b1);
    chk(logical_unit_field, 4'h5);
    rchk(ADDR_ERR_FEAT, c);
    rchk(ADDR_STAT_CMD, 32'h64);
  endtask : t_diag
  task t_ident;
    logic [31:0] d;
    host_u.wr(ADDR_STAT_CMD, CMD_IDENT);
    wait_n(2);
    chk(intrq, 1'b1);
    rchk(ADDR_BCNT_LO, 32'h50);
    rchk(ADDR_BCNT_HI, 32'h0);
    rchk(ADDR_REASON_SCNT, 32'h2);
    rchk(ADDR_STAT_CMD, 32'h6c);
    for (int i = 0; i < IDENT_LEN; i++)
    begin
      host_u.rd(ADDR_DATA, d);
      if (i >= 16 && i < 64)
        chk(d >= 32'h20 && d < 32'h7f, 1'b1);
      else if (i > 2)
        chk(d, 32'h0);
    end
    chk(intrq, 1'b1);
    rchk(ADDR_REASON_SCNT, 32'h3);
    rchk(ADDR_STAT_CMD, 32'h64);
  endtask : t_ident
  task t_pkt(input logic dma);
    logic [15:0] bc;
    bc = dma ? 16'h0800 : 16'h1234;
    host_u.wr(ADDR_BCNT_LO, 8'h00);
    host_u.wr(ADDR_BCNT_HI, 8'h08);
    host_u.wr(ADDR_ERR_FEAT, {7'h0, dma});
    host_u.wr(ADDR_STAT_CMD, CMD_PKT);
    wait_n(1);
    chk(pkt_start, 1'b1);
    chk(dma_sel, dma);
    rchk(ADDR_REASON_SCNT, 32'h1);
    xfer_end <= 1'b1;
    wait_n(1);
    // the dma run moves data towards the device
    {xfer_end, xfer_req, xfer_dir, xfer_count} <= {2'b01, ~dma, 16'h1234};
    wait_n(1);
    xfer_req <= 1'b0;
    wait_n(1);
    chk(intrq, 1'b1);
    rchk(ADDR_BCNT_LO, bc[7:0]);
    rchk(ADDR_BCNT_HI, bc[15:8]);
    host_u.wr(ADDR_BCNT_LO, 8'hff);
    rchk(ADDR_BCNT_LO, bc[7:0]);
    rchk(ADDR_REASON_SCNT, {30'h0, ~dma, 1'b0});
    {xfer_end, cmd_err} <= {1'b1, ~dma};
    wait_n(1);
    {xfer_end, cmd_done} <= 2'b01;
    wait_n(1);
    cmd_done <= 1'b0;
    rchk(ADDR_REASON_SCNT, 32'h3);
    rchk(ADDR_STAT_CMD, {24'h0, 7'h32, ~dma});
  endtask : t_pkt
  task t_srst;
    logic [31:0] d;
    motor_stopped <= 1'b1;
    host_u.wr(ADDR_STAT_CMD, CMD_SRST);
    host_u.rd(ADDR_STAT_CMD, d);
    chk(d[7], 1'b1);
    host_u.poll(d);
    chk(d, 32'h64);
    chk(motor_seen, 1'b1);
    chk(pio_mode, PIO_MODE_RST);
    chk(dma_mode, DMA_MODE_RST);
    rchk(ADDR_ERR_FEAT, ERR_NONE);
  endtask : t_srst
  initial
  begin
    nrst_i = 1'b0;
    repeat (10) @(posedge clk_i);
    nrst_i <= 1'b1;
    wait_n(1);
    t_idle;
    t_abort(CMD_NOP);
    t_abort(8'h55);
    t_setf(8'h00);
    t_setf(8'h12);
    t_setf(8'h0b);
    t_setf(8'h21);
    // reserved method must abort and leave the dma mode alone
    host_u.wr(ADDR_ERR_FEAT, 8'h83);
    host_u.wr(ADDR_REASON_SCNT, 8'h18);
    t_abort(CMD_SETF);
    chk(dma_mode, exp_dma);
    host_u.wr(ADDR_ERR_FEAT, 8'h03);
    t_abort(CMD_SETF);
    foreach (codes[i])
      t_diag(codes[i]);
    t_ident;
    t_pkt(1'b0);
    t_pkt(1'b1);
    t_srst;
    test_done;
  end
  // about fourteen times the expected run length
  initial
  begin
    #40000;
    n_errors++;
    test_done;
  end
endmodule : odt_task_file_bench
bind odt_task_file odt_task_file_assertions chk_u (.clk_i(clk_i),
  .nrst_i(nrst_i), .addr_i(addr_i), .wdata_i(wdata_i), .we_i(we_i),
  .re_i(re_i), .rdata_o(rdata_o), .intrq_o(intrq_o),
  .diag_done_i(diag_done_i), .diag_code_i(diag_code_i),
  .xfer_req_i(xfer_req_i), .cmd_done_i(cmd_done_i),
  .motor_stopped_i(motor_stopped_i), .motor_start_o(motor_start_o),
  .pkt_start_o(pkt_start_o),
  .logical_unit_field_o(logical_unit_field_o));
